// file: pkg/sigmod_pkg.sv
// Package: register map, field positions and source codes of the signal modulator
package sigmod_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_SOURCE  = 4'h4;
    localparam logic [3:0] OFF_CARRIER = 4'h8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_ENABLE   = 15;
    localparam int CTL_SIDL     = 13;
    localparam int CTL_PIN_OE   = 6;
    localparam int CTL_SLEW     = 5;
    localparam int CTL_POL      = 4;
    localparam int CTL_SWBIT    = 0;
    localparam logic [15:0] CTL_MASK  = 16'ha071;
    localparam logic [15:0] CTL_RESET = 16'h0020;

    // ------------------------------------------------------------
    // Source register fields
    // ------------------------------------------------------------
    localparam int SRC_ODIS = 7;
    localparam logic [15:0] SRC_MASK = 16'h008f;

    // ------------------------------------------------------------
    // Carrier register fields
    // ------------------------------------------------------------
    localparam int CAR_HODIS = 15;
    localparam int CAR_HPOL  = 14;
    localparam int CAR_HSYNC = 13;
    localparam int CAR_LODIS = 7;
    localparam int CAR_LPOL  = 6;
    localparam int CAR_LSYNC = 5;
    localparam logic [15:0] CAR_MASK = 16'hefef;
    localparam logic [15:0] CAR_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Modulator source codes
    // ------------------------------------------------------------
    localparam logic [3:0] MS_SOFT   = 4'h0;
    localparam logic [3:0] MS_PIN    = 4'h1;
    localparam logic [3:0] MS_SPI1   = 4'h2;
    localparam logic [3:0] MS_SPI2   = 4'h3;
    localparam logic [3:0] MS_UART1  = 4'h4;
    localparam logic [3:0] MS_PWM1   = 4'h8;
    localparam logic [3:0] MS_SPI3   = 4'he;

    // ------------------------------------------------------------
    // Carrier source codes
    // ------------------------------------------------------------
    localparam logic [3:0] CS_GND    = 4'h0;
    localparam logic [3:0] CS_PIN1   = 4'h1;
    localparam logic [3:0] CS_PIN2   = 4'h2;
    localparam logic [3:0] CS_REFCLK = 4'h3;
    localparam logic [3:0] CS_PWM1   = 4'h4;
    localparam logic [3:0] CS_PWM6   = 4'h9;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: core/signal_modulator.sv
// Signal modulator: AXI4-Lite registers, source and carrier selection, mixing
//
// What this block does
// - Output is the carrier that the modulator signal selects: high carrier while it is high, low carrier while it is low.
// - Enable bit 15 set mixes inputs; clear gives no output.
// - Stop-in-idle bit 13 halts operation while device idles.
// - Pin output enable bit 6 gates the result onto the pin.
// - Slew-limit bit 5 drives pin slew control; resets set.
// - Output polarity bit 4 inverts the modulated output.
// - Software bit 0 is modulator signal only when source is zero.
// - Source field picks pin, serial, UART, PWM or third serial output.
// - Source output disable bit 7 blocks source peripheral's own pin.
// - Output disable is written over the bus and cleared by power-on reset; source field survives it.
// - High carrier field picks ground, pins, reference clock or PWM.
// - Low carrier field uses identical encoding to high carrier.
// - High carrier polarity bit 14 inverts high carrier.
// - Low carrier polarity bit 6 inverts low carrier.
// - High sync defers high-to-low switch until high carrier falls.
// - Low sync defers low-to-high switch until low carrier falls.
// - Carrier output disable bits block carrier peripherals' own pins.
// - Unimplemented bits read zero and ignore writes.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module signal_modulator
    import sigmod_pkg::*;
(
    input  wire logic        core_clk,               // System clock, 10 MHz
    input  wire logic        srst,                   // Synchronous reset, high
    input  wire logic        por,                    // Power-on reset, high
    input  wire logic        device_idle,            // Device in idle mode
    input  wire logic        modulator_input_pin,    // External modulator pin
    input  wire logic        carrier_input_pin_one,  // External carrier pin 1
    input  wire logic        carrier_input_pin_two,  // External carrier pin 2
    input  wire logic        reference_clock_output, // Reference clock
    input  wire logic [2:0]  spi_out,                // Serial outputs 1..3
    input  wire logic [3:0]  uart_tx,                // UART transmit 1..4
    input  wire logic [5:0]  pwm_out,                // Compare/PWM 1..6
    output logic             modulated_output_pin,   // Modulated output
    output logic             pin_drive_n,            // Pin enable, low drives
    output logic             output_slew_limit,      // Pin slew limiting
    output logic [2:0]       spi_pin_disable,        // Block serial pins
    output logic [3:0]       uart_pin_disable,       // Block UART pins
    output logic [5:0]       pwm_pin_disable,        // Block PWM pins
    output logic             ref_pin_disable,        // Block reference pin
    input  wire logic [3:0]  s_axi_awaddr,           // Write address
    input  wire logic        s_axi_awvalid,          // Write address valid
    output logic             s_axi_awready,          // Write address ready
    input  wire logic [31:0] s_axi_wdata,            // Write data
    input  wire logic [3:0]  s_axi_wstrb,            // Write strobes
    input  wire logic        s_axi_wvalid,           // Write data valid
    output logic             s_axi_wready,           // Write data ready
    output logic [1:0]       s_axi_bresp,            // Write response
    output logic             s_axi_bvalid,           // Write response valid
    input  wire logic        s_axi_bready,           // Write response ready
    input  wire logic [3:0]  s_axi_araddr,           // Read address
    input  wire logic        s_axi_arvalid,          // Read address valid
    output logic             s_axi_arready,          // Read address ready
    output logic [31:0]      s_axi_rdata,            // Read data
    output logic [1:0]       s_axi_rresp,            // Read response
    output logic             s_axi_rvalid,           // Read data valid
    input  wire logic        s_axi_rready            // Read data ready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [0:0] {SEL_LOW = 1'b0, SEL_HIGH = 1'b1} car_sel_t;

    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] src;
        logic [15:0] car;
        logic [1:0]  sync_min;
        logic [1:0]  sync_c1;
        logic [1:0]  sync_c2;
        logic        hi_prev;
        logic        lo_prev;
        car_sel_t    sel;
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        out;
        logic        drive_n;
        logic        slew;
        logic [2:0]  spi_dis;
        logic [3:0]  uart_dis;
        logic [5:0]  pwm_dis;
        logic        ref_dis;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Carrier decode shared by both carrier paths; reserved codes give ground
    function automatic logic pick_carrier(input logic [3:0] code, input logic p1, input logic p2,
                                          input logic rclk, input logic [5:0] pwm);
        logic r;
        r = 1'b0;
        if (code == CS_PIN1) begin
            r = p1;
        end else if (code == CS_PIN2) begin
            r = p2;
        end else if (code == CS_REFCLK) begin
            r = rclk;
        end else if (code >= CS_PWM1 && code <= CS_PWM6) begin
            r = pwm[3'(code - CS_PWM1)];
        end
        return r;
    endfunction

    // One-hot of the PWM unit a carrier code points at
    function automatic logic [5:0] carrier_pwm_hot(input logic [3:0] code);
        logic [5:0] r;
        r = 6'h00;
        if (code >= CS_PWM1 && code <= CS_PWM6) begin
            r[3'(code - CS_PWM1)] = 1'b1;
        end
        return r;
    endfunction

    // Merge a write into a register, keeping only implemented bits
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] mask);
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r & mask;
    endfunction

    // ------------------------------------------------------------
    // Combinational path
    // ------------------------------------------------------------
    logic       running;
    logic       mod_sig;
    logic       hi_car;
    logic       lo_car;
    logic [3:0] ms;
    logic [3:0] chf;
    logic [3:0] clf;
    logic       mixed;
    logic       do_wr;
    logic       rd_take;

    // Register update, selection and bus handshakes all in one pass
    always_comb begin
        st_next = st_reg;
        ms  = st_reg.src[3:0];
        chf = st_reg.car[11:8];
        clf = st_reg.car[3:0];
        running = st_reg.ctl[CTL_ENABLE] && !(st_reg.ctl[CTL_SIDL] && device_idle);

        // Two-flop synchronisers; only bit 1 is used downstream
        st_next.sync_min = {st_reg.sync_min[0], modulator_input_pin};
        st_next.sync_c1  = {st_reg.sync_c1[0], carrier_input_pin_one};
        st_next.sync_c2  = {st_reg.sync_c2[0], carrier_input_pin_two};

        // Modulator source select
        mod_sig = 1'b0;
        if (ms == MS_SOFT) begin
            mod_sig = st_reg.ctl[CTL_SWBIT];
        end else if (ms == MS_PIN) begin
            mod_sig = st_reg.sync_min[1];
        end else if (ms == MS_SPI1 || ms == MS_SPI2) begin
            mod_sig = spi_out[2'(ms - MS_SPI1)];
        end else if (ms >= MS_UART1 && ms < MS_PWM1) begin
            mod_sig = uart_tx[2'(ms - MS_UART1)];
        end else if (ms >= MS_PWM1 && ms < MS_SPI3) begin
            mod_sig = pwm_out[3'(ms - MS_PWM1)];
        end else if (ms == MS_SPI3) begin
            mod_sig = spi_out[2];
        end

        // Carriers with polarity, same decode for both
        hi_car = pick_carrier(chf, st_reg.sync_c1[1], st_reg.sync_c2[1], reference_clock_output, pwm_out)
                 ^ st_reg.car[CAR_HPOL];
        lo_car = pick_carrier(clf, st_reg.sync_c1[1], st_reg.sync_c2[1], reference_clock_output, pwm_out)
                 ^ st_reg.car[CAR_LPOL];
        st_next.hi_prev = hi_car;
        st_next.lo_prev = lo_car;

        // Carrier switching; sync waits for a falling edge of the current carrier
        if (st_reg.sel == SEL_HIGH && !mod_sig) begin
            if (!st_reg.car[CAR_HSYNC] || (st_reg.hi_prev && !hi_car)) begin
                st_next.sel = SEL_LOW;
            end
        end else if (st_reg.sel == SEL_LOW && mod_sig) begin
            if (!st_reg.car[CAR_LSYNC] || (st_reg.lo_prev && !lo_car)) begin
                st_next.sel = SEL_HIGH;
            end
        end

        // Mix: output is the held carrier, high carrier while sel is high, low carrier while sel is low
        mixed = (st_reg.sel == SEL_HIGH) ? hi_car : (lo_car & 1'b1);
        mixed = mixed & (mod_sig | (st_reg.sel == SEL_HIGH)) | (mixed & (st_reg.sel == SEL_LOW));
        st_next.out = running & (mixed ^ st_reg.ctl[CTL_POL]);
        st_next.drive_n = !(running && st_reg.ctl[CTL_PIN_OE]);
        st_next.slew = st_reg.ctl[CTL_SLEW];

        // Peripheral pin disables for the chosen sources
        st_next.spi_dis  = 3'h0;
        st_next.uart_dis = 4'h0;
        st_next.pwm_dis  = 6'h00;
        st_next.ref_dis  = 1'b0;
        if (running && st_reg.src[SRC_ODIS]) begin
            if (ms == MS_SPI1 || ms == MS_SPI2) begin
                st_next.spi_dis[2'(ms - MS_SPI1)] = 1'b1;
            end else if (ms == MS_SPI3) begin
                st_next.spi_dis[2] = 1'b1;
            end else if (ms >= MS_UART1 && ms < MS_PWM1) begin
                st_next.uart_dis[2'(ms - MS_UART1)] = 1'b1;
            end else if (ms >= MS_PWM1 && ms < MS_SPI3) begin
                st_next.pwm_dis[3'(ms - MS_PWM1)] = 1'b1;
            end
        end
        if (running && st_reg.car[CAR_HODIS]) begin
            st_next.pwm_dis = st_next.pwm_dis | carrier_pwm_hot(chf);
            st_next.ref_dis = st_next.ref_dis | (chf == CS_REFCLK);
        end
        if (running && st_reg.car[CAR_LODIS]) begin
            st_next.pwm_dis = st_next.pwm_dis | carrier_pwm_hot(clf);
            st_next.ref_dis = st_next.ref_dis | (clf == CS_REFCLK);
        end

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
            st_next.w_got  = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
        if (do_wr) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = RESP_OKAY;
            unique case (st_reg.aw_addr)
                OFF_CONTROL: begin
                    st_next.ctl = merge(st_reg.ctl, st_reg.w_data, st_reg.w_strb, CTL_MASK);
                end
                OFF_SOURCE: begin
                    // Source field bits 3:0 and disable bit 7 are writable; of the two resets only power-on reset clears the disable bit
                    st_next.src = merge(st_reg.src, st_reg.w_data, st_reg.w_strb, SRC_MASK);
                end
                OFF_CARRIER: begin
                    st_next.car = merge(st_reg.car, st_reg.w_data, st_reg.w_strb, CAR_MASK);
                end
                default: begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // Read channel: one read in flight, data one cycle after address
        rd_take = s_axi_arvalid && !st_reg.rvalid;
        if (rd_take) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                OFF_CONTROL: st_next.rdata = {16'h0000, st_reg.ctl & CTL_MASK};
                OFF_SOURCE:  st_next.rdata = {16'h0000, st_reg.src & SRC_MASK};
                OFF_CARRIER: st_next.rdata = {16'h0000, st_reg.car & CAR_MASK};
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // Power-on reset: only the disable bit changes, source field survives
        if (por) begin
            st_next.src[SRC_ODIS] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Source register rides through the core reset; power-on reset clears only its disable bit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.ctl <= CTL_RESET;
            st_reg.car <= CAR_RESET;
            st_reg.drive_n <= 1'b1;
            st_reg.slew <= 1'b1;
            st_reg.src <= st_reg.src;
            if (por) begin
                st_reg.src[SRC_ODIS] <= 1'b0;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign modulated_output_pin = st_reg.out;
    assign pin_drive_n          = st_reg.drive_n;
    assign output_slew_limit    = st_reg.slew;
    assign spi_pin_disable      = st_reg.spi_dis;
    assign uart_pin_disable     = st_reg.uart_dis;
    assign pwm_pin_disable      = st_reg.pwm_dis;
    assign ref_pin_disable      = st_reg.ref_dis;
    assign s_axi_awready        = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready         = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_bvalid         = st_reg.bvalid;
    assign s_axi_bresp          = st_reg.bresp;
    assign s_axi_arready        = !st_reg.rvalid;
    assign s_axi_rvalid         = st_reg.rvalid;
    assign s_axi_rdata          = st_reg.rdata;
    assign s_axi_rresp          = st_reg.rresp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    disabled_no_out_a: assert property (@(posedge core_clk) disable iff (srst)
        !st_reg.ctl[CTL_ENABLE] |=> !modulated_output_pin)
        else $error("output active while disabled");
    idle_stop_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_reg.ctl[CTL_SIDL] && device_idle) |=> (!modulated_output_pin && pin_drive_n))
        else $error("output active while stopped in idle");
    pin_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        !st_reg.ctl[CTL_PIN_OE] |=> pin_drive_n)
        else $error("pin driven with output enable clear");
    slew_follow_a: assert property (@(posedge core_clk) disable iff (srst)
        ##1 output_slew_limit == $past(st_reg.ctl[CTL_SLEW]))
        else $error("slew control does not follow register");
    soft_mod_a: assert property (@(posedge core_clk) disable iff (srst)
        (running && ms == MS_SOFT && !st_reg.ctl[CTL_SWBIT] && st_reg.sel == SEL_LOW
         && !st_reg.ctl[CTL_POL] && clf == CS_GND && !st_reg.car[CAR_LPOL]) |=> !modulated_output_pin)
        else $error("output high with ground carrier");
    src_por_a: assert property (@(posedge core_clk)
        por |=> !st_reg.src[SRC_ODIS])
        else $error("source disable survives power-on reset");
    hsync_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_reg.sel == SEL_HIGH && st_reg.car[CAR_HSYNC] && !(st_reg.hi_prev && !hi_car))
        |=> st_reg.sel == SEL_HIGH)
        else $error("high carrier left without falling edge");
    lsync_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_reg.sel == SEL_LOW && st_reg.car[CAR_LSYNC] && !(st_reg.lo_prev && !lo_car))
        |=> st_reg.sel == SEL_LOW)
        else $error("low carrier left without falling edge");
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (srst)
        s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12] == 1'b0))
        else $error("unimplemented bits read nonzero");

endmodule
`default_nettype wire

// file: verif/periph_model.sv
// Model of the peripheral outputs and external pins that feed the modulator
`timescale 1ns/100ps
`default_nettype none
module periph_model (
    input  wire logic        core_clk, // System clock
    input  wire logic [16:0] pat,      // Levels asked for by the bench
    output logic             mod_pin,  // External modulator pin
    output logic [1:0]       cin,      // Carrier pins one and two
    output logic             ref_clk,  // Reference clock output
    output logic [2:0]       spi,      // Serial outputs
    output logic [3:0]       uart,     // Transmit outputs
    output logic [5:0]       pwm       // Compare/PWM outputs
);
    // Peripherals change from their own flops, never in the bench's time step
    always_ff @(posedge core_clk) begin
        {pwm, uart, spi, ref_clk, cin, mod_pin} <= pat;
    end
endmodule
`default_nettype wire

// file: verif/data_signal_modulator_tb.sv
// Self-checking bench for the signal modulator
`timescale 1ns/100ps
`default_nettype none
module data_signal_modulator_tb;
    import sigmod_pkg::*;
    logic core_clk = 0, srst = 1, por = 1, idle = 0, mp, ref_clk, out, drv_n, slew, ref_dis;
    logic [16:0] pat = '0;
    logic [1:0] cin, bresp, rresp, rs;
    logic [2:0] spi, spi_dis;
    logic [3:0] uart, uart_dis, awaddr = '0, araddr = '0, wstrb = '0;
    logic [5:0] pwm, pwm_dis;
    logic [31:0] wdata = '0, rdata, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    int n_fail = 0, n_compared = 0, cyc = 0;
    periph_model i_peer (.core_clk(core_clk), .pat(pat), .mod_pin(mp), .cin(cin), .ref_clk(ref_clk), .spi(spi),
        .uart(uart), .pwm(pwm));
    signal_modulator i_dut (.core_clk(core_clk), .srst(srst), .por(por), .device_idle(idle),
        .modulator_input_pin(mp), .carrier_input_pin_one(cin[0]), .carrier_input_pin_two(cin[1]),
        .reference_clock_output(ref_clk), .spi_out(spi), .uart_tx(uart), .pwm_out(pwm),
        .modulated_output_pin(out), .pin_drive_n(drv_n), .output_slew_limit(slew), .spi_pin_disable(spi_dis),
        .uart_pin_disable(uart_dis), .pwm_pin_disable(pwm_dis), .ref_pin_disable(ref_dis),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ----------------------------------------
    // Bus master: holds each channel until its own ready
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, 16'h0000, d, 4'h3, 3'b111};
        forever begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        forever begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        {rd, rs} = {rdata, rresp};
        rready <= 0;
    endtask
    // Expected carrier and modulator levels from the requested pattern
    function automatic logic car(input logic [3:0] c);
        if (c == 4'h0) return 1'b0;
        return (c <= 4'h9) ? pat[(c <= 4'h3) ? c : 7 + c] : 1'b0;
    endfunction
    function automatic logic src(input logic [3:0] m);
        if (m == 4'h0 || m == 4'hf) return 1'b0;
        return (m == 4'h1) ? pat[0] : (m == 4'he) ? pat[6] : (m <= 4'h3) ? pat[2 + m] : pat[3 + m];
    endfunction
    // Lets the pin synchronisers and the peripheral flops settle
    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        chk("slew", 1, slew);
        chk("drive_n", 1, drv_n);
        rd_reg(OFF_CONTROL);
        chk("control", 32'h20, rd);
        rd_reg(OFF_CARRIER);
        chk("carrier", 0, rd);
        wr(OFF_CONTROL, 16'hffff);
        rd_reg(OFF_CONTROL);
        chk("control", 32'ha071, rd);
        wr(OFF_SOURCE, 16'hffff);
        rd_reg(OFF_SOURCE);
        chk("source", 32'h008f, rd);
        wr(OFF_CARRIER, 16'hffff);
        rd_reg(OFF_CARRIER);
        chk("carrier", 32'hefef, rd);
        wr(4'hc, 16'h1234);
        chk("bresp", RESP_SLVERR, rs);
        rd_reg(4'hc);
        chk("rresp", RESP_SLVERR, rs);
        $display("registers done");
    endtask
    task automatic t_soft();
        wr(OFF_SOURCE, 16'(MS_SOFT));
        wr(OFF_CARRIER, {4'h0, CS_REFCLK, 8'h00});
        pat <= 17'h8;
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CONTROL, 16'h8040 | {11'h0, i[1], 3'h0, i[0]});
            settle();
            chk("out", i[0] ^ i[1], out);
            chk("drive_n", 0, drv_n);
        end
        wr(OFF_CONTROL, 16'h8001);
        settle();
        chk("drive_n", 1, drv_n);
        wr(OFF_CONTROL, 16'h2041);
        settle();
        chk("drive_n", 1, drv_n);
        wr(OFF_CONTROL, 16'ha041);
        idle <= 1;
        settle();
        chk("out idle", 0, out);
        wr(OFF_CONTROL, 16'h8041);
        settle();
        chk("out idle", 1, out);
        idle <= 0;
        // High carrier from pin one with sync: the switch to low waits for its falling edge
        wr(OFF_CARRIER, 16'h2100);
        pat <= 17'h2;
        settle();
        wr(OFF_CONTROL, 16'h8040);
        settle();
        chk("out sync hold", 1, out);
        pat <= 17'h0;
        settle();
        pat <= 17'h2;
        settle();
        chk("out sync switch", 0, out);
        $display("software bit done");
    endtask
    task automatic t_carrier();
        wr(OFF_SOURCE, 16'(MS_PIN));
        wr(OFF_CONTROL, 16'h8040);
        pat <= 17'h14c0f;
        for (int i = 0; i < 26; i++) begin
            wr(OFF_CARRIER, {1'b0, i >= 16, 2'b00, 4'(i % 16), 8'h00});
            settle();
            chk("out carrier", car(4'(i % 16)) ^ (i >= 16), out);
        end
        $display("carrier select done");
    endtask
    task automatic t_source();
        wr(OFF_CARRIER, {4'h0, CS_REFCLK, 8'h00});
        for (int m = 1; m < 16; m++) begin
            wr(OFF_SOURCE, 16'(m));
            for (int k = 0; k < 2; k++) begin
                pat <= (k ? 17'h15555 : 17'h0aaaa) | 17'h8;
                settle();
                chk("out source", src(4'(m)), out);
            end
        end
        $display("source select done");
    endtask
    task automatic t_odis();
        wr(OFF_CARRIER, 16'h8400);
        settle();
        chk("pwm_dis high", 1, pwm_dis[0]);
        wr(OFF_CARRIER, 16'h0084);
        settle();
        chk("pwm_dis low", 1, pwm_dis[0]);
        wr(OFF_CARRIER, 16'h0004);
        settle();
        chk("pwm_dis off", 0, pwm_dis[0]);
        wr(OFF_SOURCE, 16'h0088);
        settle();
        chk("pwm_dis source", 1, pwm_dis[0]);
        srst <= 1;
        repeat (2) @(posedge core_clk);
        srst <= 0;
        rd_reg(OFF_SOURCE);
        chk("source kept", 32'h88, rd);
        {srst, por} <= 2'b11;
        repeat (2) @(posedge core_clk);
        {srst, por} <= 2'b00;
        rd_reg(OFF_SOURCE);
        chk("source por", 32'h8, rd);
        $display("output disable done");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        {srst, por} <= 2'b00;
        t_regs();
        t_soft();
        t_carrier();
        t_source();
        t_odis();
        give_verdict();
    end
endmodule
`default_nettype wire
